/* File: bench/ctl_model.sv */
// Outside motion controller model driving one pulse and direction pair
`timescale 1ns/100ps
module ctl_model (
  // Clock
  input wire logic clock,
  // Driven pair
  output logic line_a,
  output logic line_b
);
  logic ra = 1'b0; // Raw phase A or pulse line
  logic rb = 1'b0; // Raw phase B or direction line
  logic pol = 1'b0; // Negative logic inverts both lines
  logic [1:0] qu [4] = '{2'b01, 2'b11, 2'b10, 2'b00}; // B leads A, counted forward
  logic [1:0] qd [4] = '{2'b10, 2'b11, 2'b01, 2'b00}; // A leads B, counted reverse
  // Line drivers always active, so both lines keep a defined level
  assign line_a = ra ^ pol;
  assign line_b = rb ^ pol;
  // Wait whole cycles, then move just after the edge
  task hold(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask : hold
  // Change logic sense; caller lets the decoder settle afterwards
  task set_pol(input logic p);
    pol = p;
  endtask : set_pol
  // One train of n pulses; half sets the rate, some callers set it above the filter ceiling
  task send(input logic [1:0] t, input int n, input logic up, input int half);
    int i;
    int k;
    if (t == 2'h2) begin
      // Direction set up a full half period before pulses
      rb = !up;
      hold(half);
    end
    for (i = 0; i < n; i++) begin
      if (t == 2'h0) begin
        // Four states per pulse
        for (k = 0; k < 4; k++) begin
          {ra, rb} = up ? qu[k] : qd[k];
          hold(half);
        end
      end else if (t == 2'h1 && !up) begin
        // Reverse pulses on the second line
        rb = 1'b1;
        hold(half);
        rb = 1'b0;
        hold(half);
      end else begin
        // Forward CW/CCW pulses and all pulse-direction pulses on the first line
        ra = 1'b1;
        hold(half);
        ra = 1'b0;
        hold(half);
      end
    end
  endtask : send
endmodule : ctl_model

/* File: bench/position_command_source_bench.sv */
// Self-checking bench for the position command source
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module position_command_source_bench;
  logic clock = 1'b0; // 40 MHz
  logic rst_n = 1'b0; // Sync reset
  logic cfg_wr = 1'b0, cfg_rd = 1'b0; // Access strobes
  logic [15:0] cfg_addr = 16'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic [31:0] cfg_rdata, position_command;
  logic cfg_ack, cfg_err, pulse_step, pulse_dir_up, move_start, motor_stop;
  logic [1:0] control_mode = 2'h0;
  logic lo_a, lo_b, hi_a, hi_b; // Pairs from the two controller models
  logic ps_asg = 1'b0, ps_in = 1'b0, ih_asg = 1'b0, ih_in = 1'b0; // Digital inputs
  logic [2:0] ih_slot = 3'h0;
  logic [2:0] sel = 3'h0; // Target index, bit two is most significant
  logic trig = 1'b0, incr = 1'b0;
  int n_fail = 0, n_tests = 0, cyc = 0, n_up = 0, n_dn = 0, i, m;
  logic [31:0] exp_pos;
  // Clock generator
  always #12.5 clock = ~clock;
  ctl_model i_lo (.clock(clock), .line_a(lo_a), .line_b(lo_b));
  ctl_model i_hi (.clock(clock), .line_a(hi_a), .line_b(hi_b));
  position_command_source i_dut (.clock(clock), .rst_n(rst_n), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .cfg_err(cfg_err), .control_mode(control_mode), .pulse_in(lo_a),
    .direction_in(lo_b), .high_speed_pulse_in(hi_a), .high_speed_direction_in(hi_b),
    .pulse_source_select_assigned(ps_asg), .pulse_source_select_input(ps_in),
    .pulse_inhibit_assigned(ih_asg), .pulse_inhibit_input_slot(ih_slot),
    .pulse_inhibit_input(ih_in), .target_select_bit_zero(sel[0]),
    .target_select_bit_one(sel[1]), .target_select_bit_two(sel[2]),
    .move_trigger(trig), .move_incremental(incr), .position_command(position_command),
    .pulse_step(pulse_step), .pulse_dir_up(pulse_dir_up), .move_start(move_start),
    .motor_stop(motor_stop));
  // Step counter by direction, plus hang guard
  always @(posedge clock) begin
    cyc++;
    if (pulse_step === 1'b1) begin
      if (pulse_dir_up === 1'b1) n_up++;
      else n_dn++;
    end
    if (cyc == 40000) begin
      n_fail++;
      wrap_up();
    end
  end
  // Verdict and end of run
  task wrap_up();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // Wait cycles, landing just after an edge
  task tick(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask : tick
  // One access; answer lands one cycle after the request edge
  task acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic e);
    cfg_wr = w;
    cfg_rd = !w;
    cfg_addr = a;
    cfg_wdata = d;
    tick(1);
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    `CHK("ack", 1'b1, cfg_ack)
    `CHK("err", e, cfg_err)
    tick(1);
  endtask : acc
  // Read and compare
  task rd(input logic [15:0] a, input logic [31:0] x, input logic e);
    acc(1'b0, a, 32'h0, e);
    `CHK("rdata", x, cfg_rdata)
  endtask : rd
  // Configure, send 3 forward and 2 reverse pulses on one pair, count steps
  task train(input logic [1:0] t, input logic p, input logic s, input logic [1:0] f,
    input logic pr, input int half, input int eu, input int ed);
    i_lo.set_pol(p);
    i_hi.set_pol(p);
    acc(1'b1, 16'h0100, {19'h0, s, 3'h0, p, 2'h0, f, 2'h0, t}, 1'b0);
    tick(250);
    n_up = 0;
    n_dn = 0;
    if (pr) begin
      i_hi.send(t, 3, 1'b1, half);
      i_hi.send(t, 2, 1'b0, half);
    end else begin
      i_lo.send(t, 3, 1'b1, half);
      i_lo.send(t, 2, 1'b0, half);
    end
    tick(250);
    `CHK("up steps", eu, n_up)
    `CHK("down steps", ed, n_dn)
  endtask : train
  // Select a target and raise the trigger
  task move(input logic [2:0] s, input logic inc);
    sel = s;
    incr = inc;
    tick(1);
    trig = 1'b1;
    tick(1);
    `CHK("start", 1'b1, move_start)
    `CHK("command", exp_pos, position_command)
    tick(1);
    `CHK("no restart", 1'b0, move_start)
    trig = 1'b0;
    tick(1);
  endtask : move
  // Main sequence
  initial begin
    tick(20);
    rst_n = 1'b1;
    rd(16'h0100, 32'h0000_0002, 1'b0);
    rd(16'h0604, 32'h0, 1'b0);
    acc(1'b1, 16'h0100, 32'h0000_1143, 1'b1);
    acc(1'b1, 16'h0100, 32'h0000_0003, 1'b1);
    rd(16'h0100, 32'h0000_0002, 1'b0);
    rd(16'h0200, 32'h0, 1'b1);
    // Every pulse type in both senses
    for (i = 0; i < 6; i++) begin
      m = (i / 2 == 0) ? 4 : 1;
      train(2'(i / 2), 1'(i % 2), 1'b0, 2'h0, 1'b0, 40, 3 * m, 2 * m);
    end
    train(2'h2, 1'b0, 1'b1, 2'h0, 1'b1, 8, 3, 2);
    train(2'h2, 1'b0, 1'b0, 2'h0, 1'b1, 8, 0, 0);
    train(2'h2, 1'b0, 1'b1, 2'h1, 1'b1, 8, 0, 0);
    train(2'h2, 1'b0, 1'b0, 2'h3, 1'b0, 40, 0, 0);
    train(2'h2, 1'b0, 1'b0, 2'h1, 1'b0, 60, 3, 2);
    ps_asg = 1'b1;
    ps_in = 1'b1;
    train(2'h2, 1'b0, 1'b0, 2'h0, 1'b1, 8, 3, 2);
    ps_asg = 1'b0;
    ih_asg = 1'b1;
    ih_in = 1'b1;
    ih_slot = 3'h7;
    tick(3);
    `CHK("stop", 1'b1, motor_stop)
    train(2'h2, 1'b0, 1'b0, 2'h0, 1'b0, 40, 0, 0);
    ih_slot = 3'h6;
    tick(3);
    `CHK("stop other slot", 1'b0, motor_stop)
    train(2'h2, 1'b0, 1'b0, 2'h0, 1'b0, 40, 3, 2);
    ih_asg = 1'b0;
    // Internal targets, absolute then incremental
    control_mode = 2'h1;
    for (i = 0; i < 8; i++) acc(1'b1, 16'(16'h0600 + 4 * i), 32'h1000 * (i + 1) + i, 1'b0);
    rd(16'h061c, 32'h0000_8007, 1'b0);
    for (i = 0; i < 8; i++) begin
      exp_pos = 32'h1000 * (i + 1) + i;
      move(3'(i), 1'b0);
    end
    for (i = 0; i < 8; i++) begin
      exp_pos = exp_pos + 32'h1000 * (i + 1) + i;
      move(3'(i), 1'b1);
    end
    acc(1'b1, 16'h0608, 32'h0000_abcd, 1'b0);
    exp_pos = 32'h0000_abcd;
    move(3'h2, 1'b0);
    // Neither position mode: command held, no start, no stop
    control_mode = 2'h2;
    ih_asg = 1'b1;
    ih_slot = 3'h7;
    sel = 3'h1;
    trig = 1'b1;
    tick(3);
    `CHK("held command", 32'h0000_abcd, position_command)
    `CHK("start outside mode", 1'b0, move_start)
    `CHK("stop outside mode", 1'b0, motor_stop)
    wrap_up();
  end
endmodule : position_command_source_bench

/* File: common/edge_if.sv */
// Carrier between top and the filter/decoder leaf
`timescale 1ns/100ps
interface edge_if;
  logic a_raw;
  logic b_raw;
  logic [7:0] min_cyc;
  logic [1:0] ptype;
  logic step;
  logic dir_up;
  modport top (output a_raw, output b_raw, output min_cyc, output ptype,
    input step, input dir_up);
  modport dec (input a_raw, input b_raw, input min_cyc, input ptype,
    output step, output dir_up);
endinterface : edge_if

/* File: common/pcs_pkg.sv */
// Constants and the ns_to_cyc helper for the position command source
// Summary of operation
// [R1] Decoder accepts pulses up to 4 Mpps
// [R2] Eight stored targets for internal mode
// [R3] Targets writable any time over serial port
// [R4] Type 0 quadrature x4, 1 CW/CCW, 2 pulse-direction
// [R5] Config 16 bits, reset 0x0002, max 0x1142
// [R6] Filter setting 0..3 sets pulse rate ceiling
// [R7] Polarity 1 inverts pulse and direction sense
// [R8] Controller limits rate per input interface
// [R9] Source 0 low pair, 1 high pair
// [R10] Source select input overrides config when assigned
// [R11] Three select bits index targets, bit two MSB
// [R12] Open contact reads 0, closed reads 1
// [R13] Move starts only on trigger rising edge
// [R14] Move absolute or incremental from previous
// [R15] Gear scaling follows source in both modes
// [R16] S-curve and smoothing follow source selection
// [R17] Inhibit in position mode blocks pulses, stops
// [R18] Inhibit honoured only on eighth digital input
// [R19] Mode 00 external pulse, 01 internal register
// [R20] Quadrature counts all edges; direction sampled per pulse
// [R21] Low limits for low pair, high for high pair
package pcs_pkg;
  localparam logic [15:0] CFG_OFFSET = 16'h0100;
  localparam logic [15:0] CFG_RESET = 16'h0002;
  localparam logic [15:0] CFG_MAX = 16'h1142;
  localparam logic [15:0] TABLE_OFFSET = 16'h0600;
  localparam int TYPE_LSB = 0;
  localparam int FILT_LSB = 4;
  localparam int POL_LSB = 8;
  localparam int SRC_LSB = 12;
  localparam logic [1:0] TYPE_QUAD = 2'h0;
  localparam logic [1:0] TYPE_CWCCW = 2'h1;
  localparam logic [1:0] TYPE_PDIR = 2'h2;
  localparam logic [1:0] MODE_PULSE = 2'h0;
  localparam logic [1:0] MODE_REG = 2'h1;
  localparam int NUM_TARGETS = 8;
  localparam int CLK_HZ = 40_000_000;
  // Minimum stable time per filter setting, in ns (half period at ceiling)
  localparam int LOW_NS0 = 301;
  localparam int LOW_NS1 = 1202;
  localparam int LOW_NS2 = 2403;
  localparam int LOW_NS3 = 4807;
  localparam int HIGH_NS0 = 75;
  localparam int HIGH_NS1 = 301;
  localparam int HIGH_NS2 = 600;
  localparam int HIGH_NS3 = 1202;
  // Half period of the fastest legal train, in ns
  localparam int MAX_RATE_HALF_NS = 125;
  localparam int PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // Least stable time rounds up, never below one cycle
  function automatic logic [7:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + PERIOD_NS - 1) / PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[7:0];
  endfunction : ns_to_cyc
endpackage : pcs_pkg

/* File: rtl/position_command_source.sv */
// Position command source: pulse decode, target table, inhibit
`timescale 1ns/100ps
module position_command_source (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Configuration write/read port
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [15:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  output logic cfg_err,
  // Control mode code
  input wire logic [1:0] control_mode,
  // Low-speed pulse pair
  input wire logic pulse_in,
  input wire logic direction_in,
  // High-speed pulse pair
  input wire logic high_speed_pulse_in,
  input wire logic high_speed_direction_in,
  // Digital input functions
  input wire logic pulse_source_select_assigned,
  input wire logic pulse_source_select_input,
  input wire logic pulse_inhibit_assigned,
  input wire logic [2:0] pulse_inhibit_input_slot,
  input wire logic pulse_inhibit_input,
  // Target selection
  input wire logic target_select_bit_zero,
  input wire logic target_select_bit_one,
  input wire logic target_select_bit_two,
  input wire logic move_trigger,
  input wire logic move_incremental,
  // Command towards gear and smoothing stages
  output logic [31:0] position_command,
  output logic pulse_step,
  output logic pulse_dir_up,
  output logic move_start,
  output logic motor_stop
);
  // Slot code of the eighth digital input
  localparam logic [2:0] EIGHTH_SLOT = 3'h7;

  // Registers kept together so that reset and update stay in one place;
  // the table lives apart because its words are written by address
  // All state but the target table in one struct
  typedef struct packed {
    logic [15:0] pulse_input_config;
    logic [31:0] rdata;
    logic ack;
    logic err;
    logic trig_prev;
    logic [31:0] cmd;
    logic step;
    logic dir_up;
    logic start;
    logic stop;
  } top_state_t;
  top_state_t s_q, s_d;

  // Stored target table, one word per target
  logic [31:0] stored_target_table [pcs_pkg::NUM_TARGETS]; // [R2]

  // Carrier to the filter and decoder leaf; the top drives the raw pair,
  // the ceiling and the type, the leaf answers with one step pulse
  edge_if e();

  // Filter ceiling per setting and path
  function automatic logic [7:0] filt_cyc(input logic hi, input logic [1:0] f);
    logic [7:0] r;
    r = 8'h01;
    unique case ({hi, f})
      3'h0: r = pcs_pkg::ns_to_cyc(pcs_pkg::LOW_NS0);
      3'h1: r = pcs_pkg::ns_to_cyc(pcs_pkg::LOW_NS1);
      3'h2: r = pcs_pkg::ns_to_cyc(pcs_pkg::LOW_NS2);
      3'h3: r = pcs_pkg::ns_to_cyc(pcs_pkg::LOW_NS3);
      3'h4: r = pcs_pkg::ns_to_cyc(pcs_pkg::HIGH_NS0);
      3'h5: r = pcs_pkg::ns_to_cyc(pcs_pkg::HIGH_NS1);
      3'h6: r = pcs_pkg::ns_to_cyc(pcs_pkg::HIGH_NS2);
      3'h7: r = pcs_pkg::ns_to_cyc(pcs_pkg::HIGH_NS3);
    endcase
    return r;
  endfunction : filt_cyc

  // Table address decode, used on read and write
  function automatic logic is_table(input logic [15:0] a);
    return (a >= pcs_pkg::TABLE_OFFSET) &&
      (a < pcs_pkg::TABLE_OFFSET + 16'(pcs_pkg::NUM_TARGETS * 4)) && (a[1:0] == 2'h0);
  endfunction : is_table

  // Config fields and decoded input signals
  logic [1:0] ptype;
  logic [1:0] pfilt;
  logic pol;
  logic hi_sel;
  logic inhibit;
  logic [2:0] sel_index;
  logic trig_rise;

  always_comb begin
    ptype = s_q.pulse_input_config[pcs_pkg::TYPE_LSB +: 2];
    pfilt = s_q.pulse_input_config[pcs_pkg::FILT_LSB +: 2];
    pol = s_q.pulse_input_config[pcs_pkg::POL_LSB];
    // Assigned input function wins over the config digit
    hi_sel = pulse_source_select_assigned ? pulse_source_select_input // [R10]
      : s_q.pulse_input_config[pcs_pkg::SRC_LSB]; // [R9]
    // Inhibit only takes effect from the eighth input slot
    inhibit = pulse_inhibit_assigned && (pulse_inhibit_input_slot == EIGHTH_SLOT)
      && pulse_inhibit_input; // [R18]
    // Closed contact is 1, bit two is most significant
    sel_index = {target_select_bit_two, target_select_bit_one,
      target_select_bit_zero}; // [R11] [R12]
    trig_rise = move_trigger && !s_q.trig_prev; // [R13]
  end

  // Drive the decoder carrier; polarity inverts both lines
  assign e.a_raw = (hi_sel ? high_speed_pulse_in : pulse_in) ^ pol; // [R7] [R9]
  assign e.b_raw = (hi_sel ? high_speed_direction_in : direction_in) ^ pol; // [R7]
  assign e.min_cyc = filt_cyc(hi_sel, pfilt); // [R6] [R21] [R1]
  assign e.ptype = ptype;

  pulse_decoder u_dec (
    .clock(clock),
    .rst_n(rst_n),
    .e(e)
  );

  // Next state
  // The port answers one cycle after the strobe; a write wins over a read
  // Refused config writes leave the register untouched and raise err with ack
  // The command count wraps silently; scaling belongs to the gear stage
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.err = 1'b0;
    s_d.start = 1'b0;
    s_d.step = 1'b0;
    s_d.trig_prev = move_trigger;
    // Register port access
    if (cfg_wr) begin
      s_d.ack = 1'b1;
      if (cfg_addr == pcs_pkg::CFG_OFFSET) begin
        // Out-of-range values refused, config kept
        if (cfg_wdata[15:0] <= pcs_pkg::CFG_MAX && cfg_wdata[31:16] == 16'h0000
            && cfg_wdata[1:0] != 2'h3 && cfg_wdata[5:4] <= 2'h3) begin // [R5]
          s_d.pulse_input_config = cfg_wdata[15:0];
        end else begin
          s_d.err = 1'b1;
        end
      end else if (!is_table(cfg_addr)) begin
        s_d.err = 1'b1;
      end
    end else if (cfg_rd) begin
      s_d.ack = 1'b1;
      if (cfg_addr == pcs_pkg::CFG_OFFSET) begin
        s_d.rdata = {16'h0000, s_q.pulse_input_config};
      end else if (is_table(cfg_addr)) begin
        s_d.rdata = stored_target_table[cfg_addr[4:2]];
      end else begin
        s_d.rdata = 32'h0000_0000;
        s_d.err = 1'b1;
      end
    end
    // Stop request follows inhibit in position modes
    s_d.stop = inhibit && (control_mode == pcs_pkg::MODE_PULSE ||
      control_mode == pcs_pkg::MODE_REG); // [R17]
    unique case (control_mode)
      // External pulse train feeds the command
      pcs_pkg::MODE_PULSE: begin // [R19]
        if (e.step && !inhibit) begin // [R17]
          s_d.step = 1'b1;
          s_d.dir_up = e.dir_up;
          s_d.cmd = e.dir_up ? s_q.cmd + 32'h1 : s_q.cmd - 32'h1;
        end
      end
      // Stored target chosen on trigger edge
      pcs_pkg::MODE_REG: begin // [R19]
        if (trig_rise) begin // [R13]
          s_d.start = 1'b1;
          s_d.cmd = move_incremental ? s_q.cmd + stored_target_table[sel_index]
            : stored_target_table[sel_index]; // [R14]
        end
      end
      default: begin
        s_d.cmd = s_q.cmd;
      end
    endcase
  end

  // Register state; table writes take effect for later selections
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.pulse_input_config <= pcs_pkg::CFG_RESET; // [R5]
    end else begin
      s_q <= s_d;
    end
  end

  // Reads of the table see the old word in the cycle of a write, so a new
  // value only applies to selections made after it has landed
  // Table storage, written before or during operation
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < pcs_pkg::NUM_TARGETS; i++) begin
        stored_target_table[i] <= 32'h0000_0000;
      end
    end else if (cfg_wr && is_table(cfg_addr)) begin
      stored_target_table[cfg_addr[4:2]] <= cfg_wdata; // [R3]
    end
  end

  // Outputs to gear scaling and smoothing stages downstream
  assign position_command = s_q.cmd; // [R15] [R16]
  assign pulse_step = s_q.step;
  assign pulse_dir_up = s_q.dir_up;
  assign move_start = s_q.start;
  assign motor_stop = s_q.stop;
  assign cfg_rdata = s_q.rdata;
  assign cfg_ack = s_q.ack;
  assign cfg_err = s_q.err;

  // Checks on the register port, the command path and the inhibit logic
  // Most watch registered state and hold one cycle after their cause; a_rate_ceiling and a_src_override hold in the same cycle
  // and none depends on the phase at which inputs are driven

  // Reset value of config
  a_cfg_reset: assert property (@(posedge clock) // [R5]
    !rst_n |=> s_q.pulse_input_config == pcs_pkg::CFG_RESET)
    else $error("bad config reset");

  // Config never exceeds ceiling
  a_cfg_max: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
    s_q.pulse_input_config <= pcs_pkg::CFG_MAX)
    else $error("config over range");

  // Oversized config write refused and register kept
  a_cfg_refuse: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
    (cfg_wr && cfg_addr == pcs_pkg::CFG_OFFSET && cfg_wdata[15:0] > pcs_pkg::CFG_MAX)
    |=> cfg_err && $stable(s_q.pulse_input_config))
    else $error("oversized config taken");

  // Config read returns the register in the low half
  a_cfg_read: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
    (cfg_rd && !cfg_wr && cfg_addr == pcs_pkg::CFG_OFFSET)
    |=> cfg_rdata == {16'h0000, $past(s_q.pulse_input_config)})
    else $error("config read wrong");

  // An error only ever comes with the answer
  a_err_with_ack: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
    cfg_err |-> cfg_ack)
    else $error("err without ack");

  // Every access is answered one cycle later
  a_ack_answer: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
    (cfg_wr || cfg_rd) |=> cfg_ack)
    else $error("access not answered");

  // Table read returns the stored word
  a_table_read: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
    (cfg_rd && !cfg_wr && is_table(cfg_addr))
    |=> cfg_rdata == $past(stored_target_table[cfg_addr[4:2]]))
    else $error("table read wrong");

  // Table write readable later
  a_table_write: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
    (cfg_wr && is_table(cfg_addr))
    |=> stored_target_table[$past(cfg_addr[4:2])] == $past(cfg_wdata))
    else $error("table write lost");

  // Fastest legal train still passes the filter on the high pair at filter setting 0
  a_rate_ceiling: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
    (hi_sel && pfilt == 2'h0)
    |-> e.min_cyc <= pcs_pkg::ns_to_cyc(pcs_pkg::MAX_RATE_HALF_NS))
    else $error("filter below rate ceiling");

  // Source select override
  a_src_override: assert property (@(posedge clock) disable iff (!rst_n) // [R10]
    pulse_source_select_assigned |-> hi_sel == pulse_source_select_input)
    else $error("override ignored");

  // Step changes command by one
  a_step_count: assert property (@(posedge clock) disable iff (!rst_n) // [R20]
    pulse_step |-> position_command - $past(position_command)
    == (pulse_dir_up ? 32'h1 : 32'hffff_ffff))
    else $error("step count wrong");

  // Pulse steps only in pulse mode and never under inhibit
  a_step_mode: assert property (@(posedge clock) disable iff (!rst_n) // [R19]
    pulse_step |-> $past(control_mode) == pcs_pkg::MODE_PULSE && !$past(inhibit))
    else $error("step outside pulse mode");

  // Inhibit blocks pulse steps
  a_inhibit_block: assert property (@(posedge clock) disable iff (!rst_n) // [R17]
    inhibit |=> !pulse_step)
    else $error("step under inhibit");

  // Inhibit raises stop in pulse mode
  a_stop_level: assert property (@(posedge clock) disable iff (!rst_n) // [R17]
    (inhibit && control_mode == pcs_pkg::MODE_PULSE) |=> motor_stop)
    else $error("inhibit without stop");

  // Stop drops once inhibit is gone
  a_stop_release: assert property (@(posedge clock) disable iff (!rst_n) // [R17]
    !inhibit |=> !motor_stop)
    else $error("stop without inhibit");

  // No stop outside the position modes
  a_stop_mode: assert property (@(posedge clock) disable iff (!rst_n) // [R17]
    (control_mode != pcs_pkg::MODE_PULSE && control_mode != pcs_pkg::MODE_REG)
    |=> !motor_stop)
    else $error("stop outside position mode");

  // Inhibit on other slot ignored
  a_inhibit_slot: assert property (@(posedge clock) disable iff (!rst_n) // [R18]
    (pulse_inhibit_input_slot != EIGHTH_SLOT) |=> !motor_stop)
    else $error("wrong slot stops");

  // Start only after a rising trigger
  a_start_edge: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
    move_start |-> $past(move_trigger) && !$past(move_trigger, 2))
    else $error("start no edge");

  // Start only in register mode
  a_start_mode: assert property (@(posedge clock) disable iff (!rst_n) // [R19]
    move_start |-> $past(control_mode) == pcs_pkg::MODE_REG)
    else $error("start outside register mode");

  // Absolute move lands on selected target
  a_abs_target: assert property (@(posedge clock) disable iff (!rst_n) // [R11] [R14]
    (control_mode == pcs_pkg::MODE_REG && trig_rise && !move_incremental && !cfg_wr)
    |=> position_command == $past(stored_target_table[sel_index]))
    else $error("abs wrong");

  // Incremental move adds the selected target
  a_incr_target: assert property (@(posedge clock) disable iff (!rst_n) // [R14]
    (control_mode == pcs_pkg::MODE_REG && trig_rise && move_incremental)
    |=> position_command == $past(position_command) + $past(stored_target_table[sel_index]))
    else $error("incremental wrong");

  // Command held outside the position modes
  a_hold_cmd: assert property (@(posedge clock) disable iff (!rst_n) // [R19]
    (control_mode != pcs_pkg::MODE_PULSE && control_mode != pcs_pkg::MODE_REG)
    |=> $stable(position_command) && !move_start && !pulse_step)
    else $error("command moved outside modes");
endmodule : position_command_source

/* File: rtl/pulse_decoder.sv */
// Noise filter and pulse train decoder
`timescale 1ns/100ps
module pulse_decoder (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Carrier from top
  edge_if.dec e
);
  // Whole state in one struct
  typedef struct packed {
    logic [1:0] filt;
    logic [1:0] cand;
    logic [7:0] cnt;
    logic step;
    logic dir_up;
  } dec_state_t;
  dec_state_t s_q, s_d;

  // Filter then decode
  always_comb begin
    s_d = s_q;
    s_d.step = 1'b0;
    // Pulses shorter than the ceiling never pass: they are dropped as noise
    if ({e.b_raw, e.a_raw} != s_q.cand) begin // [R6]
      s_d.cand = {e.b_raw, e.a_raw};
      s_d.cnt = 8'h00;
    end else if (s_q.cand != s_q.filt) begin
      if (s_q.cnt + 8'h01 >= e.min_cyc) begin
        s_d.filt = s_q.cand;
        s_d.cnt = 8'h00;
        unique case (e.ptype)
          // Every edge of both phases counts; lead phase sets direction
          pcs_pkg::TYPE_QUAD: begin // [R4] [R20]
            s_d.step = 1'b1;
            s_d.dir_up = (s_q.filt[0] ^ s_q.cand[1]);
          end
          // Rising edge on A is forward, on B reverse
          pcs_pkg::TYPE_CWCCW: begin // [R4]
            if (s_q.cand[0] & ~s_q.filt[0]) begin
              s_d.step = 1'b1;
              s_d.dir_up = 1'b1;
            end else if (s_q.cand[1] & ~s_q.filt[1]) begin
              s_d.step = 1'b1;
              s_d.dir_up = 1'b0;
            end
          end
          // Direction sampled at each rising pulse edge
          pcs_pkg::TYPE_PDIR: begin // [R4] [R20]
            if (s_q.cand[0] & ~s_q.filt[0]) begin
              s_d.step = 1'b1;
              s_d.dir_up = ~s_q.cand[1];
            end
          end
          default: begin
            s_d.step = 1'b0;
          end
        endcase
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
    end
  end

  // Register the state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign e.step = s_q.step;
  assign e.dir_up = s_q.dir_up;

  // A step is one cycle wide
  a_step_single: assert property (@(posedge clock) disable iff (!rst_n) // [R20]
    s_q.step |=> !s_q.step) else $error("step longer than one cycle");
endmodule : pulse_decoder
